/* File: bench/i2c_module_control_tb_top.sv */
// Self-checking bench: APB register access, slave traffic and master sequences.
// Assumes the defines header on the include path and pull-ups on both lines.
`include "i2c_module_control_defines.svh"
module i2c_module_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_module_control_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic chipIdle = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sclOut, sclOeN, sdaOut, sdaOeN, rxPulse, generalCallPulse;
  logic mSclLow, mSdaLow, rxSeen, gcSeen, ack, err;
  logic [7:0] lastRx;
  pad_s pad;
  int n_errors = 0, n_checks = 0;
  wire scl = ~(mSclLow | ~sclOeN);
  wire sda = ~(mSdaLow | ~sdaOeN);
  always #4 clk = ~clk;
  i2c_module_control i_i2c_module_control (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chipIdle(chipIdle), .sclIn(scl), .sdaIn(sda),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .pad(pad),
    .rxPulse(rxPulse), .generalCallPulse(generalCallPulse));
  i2c_remote_master i_i2c_remote_master (.clk(clk), .scl(scl), .sda(sda),
    .sclLow(mSclLow), .sdaLow(mSdaLow));
  // Pulses last one cycle, so they are caught here rather than polled
  always @(posedge clk) begin
    if (rxPulse === 1'b1) rxSeen <= 1'b1;
    if (generalCallPulse === 1'b1) gcSeen <= 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(what, exp, q);
  endtask
  task automatic xfer(input logic [7:0] b, input logic e, input string what);
    i_i2c_remote_master.send(b, ack);
    chk(what, {31'h0, e}, {31'h0, ack});
  endtask
  task automatic frame(input logic [7:0] b, input logic e, input string what);
    i_i2c_remote_master.start();
    xfer(b, e, what);
    i_i2c_remote_master.stop();
  endtask
  task automatic relieve();
    forever begin
      while (!(sclOeN === 1'b0 && mSclLow === 1'b0)) @(posedge clk);
      rd_chk("release cleared", `OFS_CONTROL, 32'h8040);
      apb(1'b0, `OFS_RECEIVE, 16'h0000);
      lastRx = q[7:0];
      apb(1'b1, `OFS_CONTROL, 16'h9040);
    end
  endtask
  task automatic wait_clear(input logic [15:0] req, input string what);
    int k;
    k = 0;
    apb(1'b1, `OFS_CONTROL, req);
    do begin
      apb(1'b0, `OFS_CONTROL, 16'h0000);
      k++;
    end while (q[4:0] !== 5'h00 && k < 60);
    chk(what, 32'h0, {27'h0, q[4:0]});
  endtask
  task automatic t_regs();
    rd_chk("control reset", `OFS_CONTROL, 32'h1000);
    chk("pad reset", 32'h0, {29'h0, pad});
    apb(1'b1, `OFS_CONTROL, 16'h7FC0);
    rd_chk("control rw", `OFS_CONTROL, 32'h3FC0);
    chk("pad bits", 32'h3, {29'h0, pad});
    chk("scl released", 32'h1, {31'h0, sclOeN});
    chk("pin levels", 32'h0, {30'h0, sclOut, sdaOut});
    apb(1'b1, `OFS_STATUS, 16'hFFFF);
    rd_chk("status low ro", `OFS_STATUS, 32'hC7C0);
    apb(1'b1, `OFS_STATUS, 16'h0000);
    apb(1'b0, 8'h18, 16'h0000);
    chk("unmapped err", 32'h1, {31'h0, err});
    // Stretching must be off before the zero write, on before the clearing write
    apb(1'b1, `OFS_CONTROL, 16'h1000);
    apb(1'b1, `OFS_CONTROL, 16'h0000);
    rd_chk("release kept", `OFS_CONTROL, 32'h1000);
    apb(1'b1, `OFS_CONTROL, 16'h0040);
    apb(1'b1, `OFS_CONTROL, 16'h0040);
    rd_chk("release written", `OFS_CONTROL, 32'h0040);
    $display("test regs done");
  endtask
  task automatic t_slave();
    apb(1'b1, `OFS_OWN_ADDR, 16'h0042);
    apb(1'b1, `OFS_CONTROL, 16'h9040);
    chk("pins owned", 32'h4, {29'h0, pad});
    fork
      begin
        i_i2c_remote_master.start();
        xfer(8'h84, 1'b1, "own addr ack");
        xfer(8'h5A, 1'b1, "data ack");
        i_i2c_remote_master.stop();
      end
      relieve();
    join_any
    disable fork;
    chk("rx pulse", 32'h1, {31'h0, rxSeen});
    chk("rx data", 32'h5A, {24'h0, lastRx});
    apb(1'b1, `OFS_CONTROL, 16'h9000);
    frame(8'h86, 1'b0, "foreign nack");
    apb(1'b1, `OFS_CONTROL, 16'h9800);
    frame(8'h86, 1'b1, "ack all");
    apb(1'b1, `OFS_CONTROL, 16'h9080);
    frame(8'h00, 1'b1, "gen call ack");
    chk("gen call pulse", 32'h1, {31'h0, gcSeen});
    apb(1'b1, `OFS_OWN_ADDR, 16'h02A5);
    apb(1'b1, `OFS_CONTROL, 16'h9400);
    i_i2c_remote_master.start();
    xfer(8'hF4, 1'b1, "wide header");
    xfer(8'hA5, 1'b1, "wide low");
    i_i2c_remote_master.stop();
    $display("test slave done");
  endtask
  task automatic t_master();
    apb(1'b1, `OFS_BAUD, 16'h0002);
    apb(1'b1, `OFS_CONTROL, 16'hB000);
    chipIdle <= 1'b1;
    apb(1'b1, `OFS_CONTROL, 16'hB001);
    repeat (20) @(posedge clk);
    rd_chk("idle holds start", `OFS_CONTROL, 32'hB001);
    chk("idle sda free", 32'h1, {31'h0, sdaOeN});
    apb(1'b1, `OFS_CONTROL, 16'h9000);
    chipIdle <= 1'b0;
    wait_clear(16'h9001, "start self clear");
    chk("start sda low", 32'h0, {31'h0, sdaOeN});
    wait_clear(16'h9002, "restart self clear");
    wait_clear(16'h9030, "ack self clear");
    chk("ack nack level", 32'h1, {31'h0, sdaOeN});
    wait_clear(16'h9004, "stop self clear");
    chk("stop sda free", 32'h1, {31'h0, sdaOeN});
    chk("stop scl free", 32'h1, {31'h0, sclOeN});
    // Another master keeps SDA low while the block sends a released one
    wait_clear(16'h9001, "start again");
    i_i2c_remote_master.pull_sda(1'b1);
    apb(1'b1, `OFS_TRANSMIT, 16'h00FF);
    repeat (30) @(posedge clk);
    apb(1'b0, `OFS_STATUS, 16'h0000);
    chk("arbitration lost", 32'h1, {31'h0, q[`ST_COLL]});
    chk("lost scl free", 32'h1, {31'h0, sclOeN});
    i_i2c_remote_master.pull_sda(1'b0);
    $display("test master done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    stop_test();
  end
  initial begin
    rxSeen = 1'b0;
    gcSeen = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_slave();
    t_master();
    stop_test();
  end
endmodule

/* File: bench/i2c_remote_master.sv */
// Behavioural remote master on the two-wire bus, driven by bench tasks.
// Assumes open-drain lines with pull-ups resolved by the bench top.
module i2c_remote_master (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 12;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge clk);
  endtask
  // A stretching slave may hold the line, so high time counts from the real rise
  task automatic rise();
    sclLow <= 1'b0;
    @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    half();
  endtask
  task automatic start();
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b1;
    half();
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaLow <= ~b[i];
      half();
      rise();
      sclLow <= 1'b1;
    end
    sdaLow <= 1'b0;
    half();
    rise();
    ack = ~sda;
    sclLow <= 1'b1;
    half();
  endtask
  // A second master holding SDA on its own, to make the block lose arbitration
  task automatic pull_sda(input logic low);
    sdaLow <= low;
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    half();
    rise();
    sdaLow <= 1'b0;
    half();
  endtask
endmodule

/* File: rtl/i2c_module_control.sv */
// Two-wire bus module: slave with 7/10-bit addressing, multi-master master,
// APB register file. Assumes open-drain pads outside and a 125 MHz clk.
// Functional notes
// - Enable hands pins to the bus logic
// - Disable releases pins to port functions
// - Stop-in-idle halts operation during chip idle
// - Clock release low stretches SCL as slave
// - Stretch on: release bit writable, hardware clears
// - Stretch off: writes only set release bit
// - Ack-all mode acknowledges every address
// - Width bit selects 10-bit or 7-bit compare
// - Two bits drive slew and threshold pads
// - General call raises a pulse when enabled
// - Stretch enable gates software and receive stretching
// - Full byte moves to buffer with pulse when buffer not full
// - Control read/write; status low six read-only
// - Baud register reloads the baud counter
// - Slave compares against own address register
// - Both address widths, slave and master
// - Master detects collisions, loses arbitration
// - Standard and fast master/slave functions
// - Start request generates Start, self-clears
// - Restart request generates Repeated Start, self-clears
// - Stop request generates Stop, self-clears
// - Ack sequence sends ack value, self-clears
//
// Added by the designer: the APB interface to the registers and the register offsets.
`include "i2c_module_control_defines.svh"
module i2c_module_control #(
  parameter int ADDR_W = 8,
  parameter int BRG_W = 9
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chipIdle,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOeN,
  output logic sdaOut,
  output logic sdaOeN,
  output i2c_module_control_pkg::pad_s pad,
  output logic rxPulse,
  output logic generalCallPulse
);
  import i2c_module_control_pkg::*;

  generate
    if (ADDR_W < 8 || BRG_W < 2 || BRG_W > 16) begin : g_bad_params
      $error("i2c_module_control: unsupported ADDR_W or BRG_W");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  function automatic logic [1:0] lastStep(input master_e s);
    case (s)
      M_START: return 2'h1;
      M_STOP, M_ACK: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  logic [15:0] conReg_reg, statReg_reg;
  logic [7:0] rcvReg_reg, trnReg_reg;
  logic [9:0] ownReg_reg;
  logic [BRG_W-1:0] baudReg_reg, brgCnt_reg;
  logic [31:0] prdata_reg;
  logic [1:0] sclSync_reg, sdaSync_reg;
  logic sclPrev_reg, sdaPrev_reg, rxPulse_reg, gcPulse_reg;
  master_e mState_reg;
  slave_e sState_reg;
  logic [1:0] mStep_reg;
  logic [3:0] mBit_reg, sBit_reg;
  logic [8:0] mShift_reg;
  logic [7:0] sShift_reg;
  logic mRx_reg, mScl_reg, mSda_reg, mActive_reg;
  logic sSda_reg, sRead_reg, sLow_reg;

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clk) begin
    if (reset) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclPrev_reg <= sclSync_reg[1];
      sdaPrev_reg <= sdaSync_reg[1];
    end
  end

  logic sclS, sdaS, sclRise, sclFall, startDet, stopDet, run;
  assign sclS = sclSync_reg[1];
  assign sdaS = sdaSync_reg[1];
  assign sclRise = sclS & ~sclPrev_reg;
  assign sclFall = ~sclS & sclPrev_reg;
  assign startDet = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopDet = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  assign run = conReg_reg[`CON_ENABLE] & ~(conReg_reg[`CON_IDLE_STOP] & chipIdle);

  // APB: read data captured in setup, so every access completes with no wait
  logic setup, access, wrCon, wrStat, wrTrn, wrOwn, wrBaud, rdRcv, mapped;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = hit(paddr, `OFS_CONTROL) | hit(paddr, `OFS_STATUS)
    | hit(paddr, `OFS_RECEIVE) | hit(paddr, `OFS_TRANSMIT)
    | hit(paddr, `OFS_OWN_ADDR) | hit(paddr, `OFS_BAUD);
  assign wrCon = access & pwrite & hit(paddr, `OFS_CONTROL);
  assign wrStat = access & pwrite & hit(paddr, `OFS_STATUS);
  assign wrTrn = access & pwrite & hit(paddr, `OFS_TRANSMIT);
  assign wrOwn = access & pwrite & hit(paddr, `OFS_OWN_ADDR);
  assign wrBaud = access & pwrite & hit(paddr, `OFS_BAUD);
  assign rdRcv = access & ~pwrite & hit(paddr, `OFS_RECEIVE);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      if (hit(paddr, `OFS_CONTROL)) prdata_reg[15:0] <= conReg_reg;
      if (hit(paddr, `OFS_STATUS)) prdata_reg[15:0] <= statReg_reg;
      if (hit(paddr, `OFS_RECEIVE)) prdata_reg[7:0] <= rcvReg_reg;
      if (hit(paddr, `OFS_TRANSMIT)) prdata_reg[7:0] <= trnReg_reg;
      if (hit(paddr, `OFS_OWN_ADDR)) prdata_reg[9:0] <= ownReg_reg;
      if (hit(paddr, `OFS_BAUD)) prdata_reg[BRG_W-1:0] <= baudReg_reg;
    end
  end

  // Baud generator; frozen while another party holds SCL low after release
  logic hold, tick, mFinish, mLost, startColl, idleFree, mTxBegin;
  logic mRxDone, mTxDone, txBusy;
  assign hold = mScl_reg & ~sclS & (mState_reg != M_IDLE);
  assign tick = (brgCnt_reg == '0) & (mState_reg != M_IDLE) & ~hold;
  always_ff @(posedge clk) begin
    if (reset || mState_reg == M_IDLE || brgCnt_reg == '0) begin
      brgCnt_reg <= baudReg_reg;
    end else if (!hold) begin
      brgCnt_reg <= brgCnt_reg - BRG_W'(1);
    end
  end

  assign idleFree = run & (mState_reg == M_IDLE) & ~|conReg_reg[4:0];
  assign mTxBegin = idleFree & mActive_reg & statReg_reg[`ST_TX_FULL];
  assign startColl = run & (mState_reg == M_IDLE) & conReg_reg[`CON_START]
    & (~sclS | ~sdaS);
  assign mLost = tick & (mState_reg == M_BITS) & (mStep_reg == 2'h2) & ~mRx_reg
    & mSda_reg & ~sdaS & (mBit_reg != 4'h8);
  assign mFinish = tick & (mStep_reg == lastStep(mState_reg)) & (mState_reg != M_BITS
    | mBit_reg == (mRx_reg ? 4'h7 : 4'h8));
  assign mRxDone = mFinish & (mState_reg == M_BITS) & mRx_reg;
  assign mTxDone = mFinish & (mState_reg == M_BITS) & ~mRx_reg;
  assign txBusy = statReg_reg[`ST_TX_FULL] | (mState_reg != M_IDLE);

  // Master sequencer: every tick advances one step of the current sequence
  always_ff @(posedge clk) begin
    if (reset || !run || mLost) begin
      mState_reg <= M_IDLE;
      mStep_reg <= 2'h0;
      mBit_reg <= 4'h0;
      mRx_reg <= 1'b0;
      mScl_reg <= 1'b1;
      mSda_reg <= 1'b1;
    end else if (mState_reg == M_IDLE) begin
      mStep_reg <= 2'h0;
      mBit_reg <= 4'h0;
      if (conReg_reg[`CON_START]) begin
        if (!startColl) mState_reg <= M_START;
      end else if (conReg_reg[`CON_RESTART]) begin
        mState_reg <= M_RESTART;
      end else if (conReg_reg[`CON_STOP]) begin
        mState_reg <= M_STOP;
      end else if (conReg_reg[`CON_ACK_SEQ]) begin
        mState_reg <= M_ACK;
      end else if (conReg_reg[`CON_RX_EN]) begin
        mState_reg <= M_BITS;
        mRx_reg <= 1'b1;
      end else if (mTxBegin) begin
        mState_reg <= M_BITS;
        mRx_reg <= 1'b0;
        mShift_reg <= {trnReg_reg, 1'b1};
      end
    end else if (tick) begin
      mStep_reg <= mStep_reg + 2'h1;
      if (mFinish) mState_reg <= M_IDLE;
      case (mState_reg)
        M_START: if (mStep_reg == 2'h0) mSda_reg <= 1'b0; else mScl_reg <= 1'b0;
        M_RESTART: begin
          if (mStep_reg == 2'h0) mSda_reg <= 1'b1;
          if (mStep_reg == 2'h1) mScl_reg <= 1'b1;
          if (mStep_reg == 2'h2) mSda_reg <= 1'b0;
          if (mStep_reg == 2'h3) mScl_reg <= 1'b0;
        end
        M_STOP: begin
          if (mStep_reg == 2'h0) mSda_reg <= 1'b0;
          if (mStep_reg == 2'h1) mScl_reg <= 1'b1;
          if (mStep_reg == 2'h2) mSda_reg <= 1'b1;
        end
        M_ACK: begin
          if (mStep_reg == 2'h0) mSda_reg <= conReg_reg[`CON_ACK_VAL];
          if (mStep_reg == 2'h1) mScl_reg <= 1'b1;
          if (mStep_reg == 2'h2) mScl_reg <= 1'b0;
        end
        M_BITS: begin
          if (mStep_reg == 2'h0) mSda_reg <= mRx_reg | mShift_reg[8];
          if (mStep_reg == 2'h1) mScl_reg <= 1'b1;
          if (mStep_reg == 2'h2) mShift_reg <= {mShift_reg[7:0], sdaS};
          if (mStep_reg == 2'h3) begin
            mScl_reg <= 1'b0;
            mBit_reg <= mBit_reg + 4'h1;
          end
        end
        default: mState_reg <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !run || startColl || mLost) begin
      mActive_reg <= 1'b0;
    end else if (mFinish && (mState_reg == M_START || mState_reg == M_RESTART)) begin
      mActive_reg <= 1'b1;
    end else if (mFinish && mState_reg == M_STOP) begin
      mActive_reg <= 1'b0;
    end
  end

  // Slave engine: samples on SCL rise, changes SDA on SCL fall
  logic slaveOn, byteDone, gcHit, hdrHit, addrHit, sAddrAck, sRxDone, sTxBegin;
  assign slaveOn = run & ~mActive_reg;
  assign byteDone = sclFall & (sBit_reg == 4'h8);
  assign gcHit = conReg_reg[`CON_GC_EN] & (sShift_reg == `GEN_CALL_ADDR) & ~sLow_reg;
  assign hdrHit = (sShift_reg[7:3] == `TEN_BIT_HDR) & (sShift_reg[2:1] == ownReg_reg[9:8]);
  assign addrHit = conReg_reg[`CON_ACK_ALL] | gcHit
    | (sLow_reg ? sShift_reg == ownReg_reg[7:0]
    : conReg_reg[`CON_WIDE] ? hdrHit & (~sShift_reg[0] | statReg_reg[`ST_TEN])
    : sShift_reg[7:1] == ownReg_reg[6:0]);
  assign sAddrAck = (sState_reg == S_ADDR) & byteDone & addrHit;
  assign sRxDone = (sState_reg == S_RX) & byteDone;
  assign sTxBegin = sclFall & ((sState_reg == S_ACK & sRead_reg) | sState_reg == S_TXACK);

  always_ff @(posedge clk) begin
    if (reset || !slaveOn || stopDet) begin
      sState_reg <= S_IDLE;
      sBit_reg <= 4'h0;
      sShift_reg <= 8'h00;
      sSda_reg <= 1'b1;
      sRead_reg <= 1'b0;
      sLow_reg <= 1'b0;
    end else if (startDet) begin
      sState_reg <= S_ADDR;
      sBit_reg <= 4'h0;
      sSda_reg <= 1'b1;
      sLow_reg <= 1'b0;
    end else if (sclRise) begin
      sBit_reg <= sBit_reg + 4'h1;
      if (sState_reg == S_ADDR || sState_reg == S_RX) sShift_reg <= {sShift_reg[6:0], sdaS};
      if (sState_reg == S_TXACK && sdaS) sState_reg <= S_IDLE;
    end else if (sclFall) begin
      if (sTxBegin) begin
        sState_reg <= S_TX;
        sShift_reg <= trnReg_reg;
        sSda_reg <= trnReg_reg[7];
        sBit_reg <= 4'h0;
      end else begin
        case (sState_reg)
          S_ADDR: if (byteDone) begin
            sState_reg <= addrHit ? S_ACK : S_IDLE;
            sSda_reg <= ~addrHit;
            sRead_reg <= sShift_reg[0] & ~sLow_reg & ~gcHit;
            sLow_reg <= conReg_reg[`CON_WIDE] & ~sLow_reg & hdrHit & ~sShift_reg[0];
          end
          S_RX: if (byteDone) begin
            sState_reg <= S_ACK;
            sSda_reg <= statReg_reg[`ST_RX_FULL]; // Refuse with NACK on overflow
          end
          S_ACK: begin
            sSda_reg <= 1'b1;
            sBit_reg <= 4'h0;
            sState_reg <= sLow_reg ? S_ADDR : S_RX;
          end
          S_TX: begin
            sSda_reg <= (sBit_reg == 4'h8) | sShift_reg[6];
            sShift_reg <= {sShift_reg[6:0], 1'b0};
            if (sBit_reg == 4'h8) sState_reg <= S_TXACK;
          end
          default: sState_reg <= S_IDLE;
        endcase
      end
    end
  end

  // Control register; hardware clears win over a same-cycle software write
  always_ff @(posedge clk) begin
    if (reset) begin
      conReg_reg <= `CON_RESET;
    end else begin
      if (wrCon) begin
        conReg_reg <= pwdata[15:0] & `CON_IMPL;
        conReg_reg[`CON_RELEASE] <= conReg_reg[`CON_STRETCH] ? pwdata[`CON_RELEASE]
          : conReg_reg[`CON_RELEASE] | pwdata[`CON_RELEASE];
      end
      if (mFinish) begin
        case (mState_reg)
          M_START: conReg_reg[`CON_START] <= 1'b0;
          M_RESTART: conReg_reg[`CON_RESTART] <= 1'b0;
          M_STOP: conReg_reg[`CON_STOP] <= 1'b0;
          M_ACK: conReg_reg[`CON_ACK_SEQ] <= 1'b0;
          default: conReg_reg[`CON_RX_EN] <= 1'b0;
        endcase
      end
      if (startColl || mLost) conReg_reg[4:0] <= 5'h00;
      if (sTxBegin || (sRxDone && conReg_reg[`CON_STRETCH])) begin
        conReg_reg[`CON_RELEASE] <= 1'b0;
      end
    end
  end

  // Status register; hardware sets are written last so they win
  always_ff @(posedge clk) begin
    if (reset) begin
      statReg_reg <= 16'h0000;
    end else begin
      if (wrStat) begin
        statReg_reg <= (statReg_reg & ~`ST_WRITABLE) | (pwdata[15:0] & `ST_WRITABLE);
      end
      if (rdRcv) statReg_reg[`ST_RX_FULL] <= 1'b0;
      if (stopDet) begin
        statReg_reg[`ST_GC] <= 1'b0;
        statReg_reg[`ST_TEN] <= 1'b0;
        statReg_reg[`ST_STOPSEEN] <= 1'b1;
        statReg_reg[`ST_STARTSEEN] <= 1'b0;
      end
      if (startDet) begin
        statReg_reg[`ST_STOPSEEN] <= 1'b0;
        statReg_reg[`ST_STARTSEEN] <= 1'b1;
      end
      if (mTxBegin || sTxBegin) statReg_reg[`ST_TX_FULL] <= 1'b0;
      if (mTxBegin) statReg_reg[`ST_TX_BUSY] <= 1'b1;
      if (mTxDone) begin
        statReg_reg[`ST_TX_BUSY] <= 1'b0;
        statReg_reg[`ST_NACK] <= mShift_reg[0];
      end
      if (wrTrn) statReg_reg[txBusy ? `ST_WCOL : `ST_TX_FULL] <= 1'b1;
      if (startColl || mLost) statReg_reg[`ST_COLL] <= 1'b1;
      if (sAddrAck) begin
        statReg_reg[`ST_DATA] <= 1'b0;
        statReg_reg[`ST_READ] <= sShift_reg[0] & ~sLow_reg;
        if (gcHit) statReg_reg[`ST_GC] <= 1'b1;
        if (sLow_reg) statReg_reg[`ST_TEN] <= 1'b1;
      end
      if (sRxDone) statReg_reg[`ST_DATA] <= 1'b1;
      if (mRxDone || sRxDone) begin
        statReg_reg[statReg_reg[`ST_RX_FULL] ? `ST_OVF : `ST_RX_FULL] <= 1'b1;
      end
    end
  end

  // Data registers and event pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      rcvReg_reg <= 8'h00;
      trnReg_reg <= 8'h00;
      ownReg_reg <= 10'h000;
      baudReg_reg <= '0;
      rxPulse_reg <= 1'b0;
      gcPulse_reg <= 1'b0;
    end else begin
      rxPulse_reg <= (mRxDone || sRxDone) && !statReg_reg[`ST_RX_FULL];
      gcPulse_reg <= sAddrAck & gcHit;
      if ((mRxDone || sRxDone) && !statReg_reg[`ST_RX_FULL]) begin
        rcvReg_reg <= mRxDone ? mShift_reg[7:0] : sShift_reg;
      end
      if (wrTrn && !txBusy) trnReg_reg <= pwdata[7:0];
      if (wrOwn) ownReg_reg <= pwdata[9:0];
      if (wrBaud) baudReg_reg <= pwdata[BRG_W-1:0];
    end
  end

  logic slaveStretch;
  assign slaveStretch = slaveOn & (sState_reg != S_IDLE)
    & ~conReg_reg[`CON_RELEASE];
  // Open drain: output level fixed low, enable low pulls the line
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOeN = ~(run & (~mScl_reg | slaveStretch));
  assign sdaOeN = ~(run & (~mSda_reg | ~sSda_reg));
  assign pad = '{portOwn: conReg_reg[`CON_ENABLE],
    slewLimitOff: conReg_reg[`CON_SLEW_OFF], altThresholds: conReg_reg[`CON_ALT_THR]};
  assign rxPulse = rxPulse_reg;
  assign generalCallPulse = gcPulse_reg;

  a_pins_released: assert property (@(posedge clk) disable iff (reset)
    !conReg_reg[`CON_ENABLE] |-> sclOeN && sdaOeN && !pad.portOwn)
    else $error("pins driven while module disabled");
  a_idle_halts: assert property (@(posedge clk) disable iff (reset)
    run ##1 !run |=> mState_reg == M_IDLE && sState_reg == S_IDLE)
    else $error("engines not halted in idle");
  a_stretch_holds: assert property (@(posedge clk) disable iff (reset)
    slaveOn && (sTxBegin || (sRxDone && conReg_reg[`CON_STRETCH])) |=> slaveStretch && !sclOeN)
    else $error("clock stretch not driving SCL low");
  a_zero_write_ignored: assert property (@(posedge clk) disable iff (reset)
    wrCon && !conReg_reg[`CON_STRETCH] && !pwdata[`CON_RELEASE]
    && conReg_reg[`CON_RELEASE] && !sTxBegin |=> conReg_reg[`CON_RELEASE])
    else $error("release bit cleared by write with stretching off");
  a_rx_pulse_full: assert property (@(posedge clk) disable iff (reset)
    rxPulse |-> statReg_reg[`ST_RX_FULL] && !$past(statReg_reg[`ST_RX_FULL]))
    else $error("receive pulse without fresh buffer");
  a_start_clears: assert property (@(posedge clk) disable iff (reset)
    mFinish && mState_reg == M_START && !wrCon |=> !conReg_reg[`CON_START]
    && mState_reg == M_IDLE && !sclOeN)
    else $error("start sequence did not end cleanly");
  a_baud_reload: assert property (@(posedge clk) disable iff (reset)
    tick && !wrBaud |=> brgCnt_reg == baudReg_reg)
    else $error("baud counter not reloaded at underflow");
  a_collision_flag: assert property (@(posedge clk) disable iff (reset)
    mLost |=> statReg_reg[`ST_COLL] && mState_reg == M_IDLE && conReg_reg[4:0] == 5'h00)
    else $error("lost arbitration not flagged");
  a_gc_pulse: assert property (@(posedge clk) disable iff (reset)
    generalCallPulse |-> conReg_reg[`CON_GC_EN] && statReg_reg[`ST_GC])
    else $error("general call pulse without enable");
endmodule

/* File: rtl/i2c_module_control_defines.svh */
// Register offsets, field positions and reset values of the two-wire bus module.
// Included by the module file; holds definitions only.
`ifndef I2C_MODULE_CONTROL_DEFINES_SVH
`define I2C_MODULE_CONTROL_DEFINES_SVH
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RECEIVE 8'h08
`define OFS_TRANSMIT 8'h0C
`define OFS_OWN_ADDR 8'h10
`define OFS_BAUD 8'h14
`define CON_RESET 16'h1000
`define CON_IMPL 16'hBFFF
`define CON_ENABLE 15
`define CON_IDLE_STOP 13
`define CON_RELEASE 12
`define CON_ACK_ALL 11
`define CON_WIDE 10
`define CON_SLEW_OFF 9
`define CON_ALT_THR 8
`define CON_GC_EN 7
`define CON_STRETCH 6
`define CON_ACK_VAL 5
`define CON_ACK_SEQ 4
`define CON_RX_EN 3
`define CON_STOP 2
`define CON_RESTART 1
`define CON_START 0
`define ST_WRITABLE 16'hC7C0
`define ST_NACK 15
`define ST_TX_BUSY 14
`define ST_COLL 10
`define ST_GC 9
`define ST_TEN 8
`define ST_WCOL 7
`define ST_OVF 6
`define ST_DATA 5
`define ST_STOPSEEN 4
`define ST_STARTSEEN 3
`define ST_READ 2
`define ST_RX_FULL 1
`define ST_TX_FULL 0
`define GEN_CALL_ADDR 8'h00
`define TEN_BIT_HDR 5'h1E
`endif

/* File: rtl/i2c_module_control_pkg.sv */
// Types shared by the two-wire bus module and its bench.
// Assumes the defines header supplies all numeric constants.
package i2c_module_control_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_RESTART = 3'b010,
    M_STOP = 3'b011, M_BITS = 3'b100, M_ACK = 3'b101
  } master_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_ACK = 3'b010,
    S_RX = 3'b011, S_TX = 3'b100, S_TXACK = 3'b101
  } slave_e;
  typedef struct packed {
    logic portOwn;
    logic slewLimitOff;
    logic altThresholds;
  } pad_s;
endpackage
